/* File: shared/dlw_consts.svh */
// Register offsets, field positions, reset values and limits of the drive limit monitor
`ifndef DLW_CONSTS_SVH
`define DLW_CONSTS_SVH

// Register byte offsets
`define DLW_OFF_CTRL      12'h000
`define DLW_OFF_BW        12'h004
`define DLW_OFF_SKIP0     12'h008
`define DLW_OFF_ILOW      12'h018
`define DLW_OFF_IHIGH     12'h01c
`define DLW_OFF_FLOW      12'h020
`define DLW_OFF_FHIGH     12'h024
`define DLW_OFF_RLOW      12'h028
`define DLW_OFF_RHIGH     12'h02c
`define DLW_OFF_PVLOW     12'h030
`define DLW_OFF_PVHIGH    12'h034
`define DLW_OFF_ROUTE     12'h038
`define DLW_OFF_STATUS    12'h03c
`define DLW_OFF_FREQ_OUT  12'h040
`define DLW_SKIP_STRIDE   12'h004

// Control register fields
`define DLW_CTRL_NOLOAD   0
`define DLW_CTRL_RANGE    1
`define DLW_CTRL_LOOP     2
`define DLW_CTRL_W        3
`define DLW_CTRL_RST      3'h1

// Frequency in 0.1 Hz steps, 16 bits
`define DLW_FW            16
`define DLW_F_120         16'h04b0
`define DLW_F_1000        16'h2710
`define DLW_BW_MAX        16'h03e8
`define DLW_F_ZERO        16'h0000
// Current in 0.1 A steps, 16 bits
`define DLW_I_ZERO        16'h0000
`define DLW_I_MAX_DEF     16'hffff
// Reference and feedback in 0.001 units, signed 32 bits
`define DLW_R_MIN         32'hc4653601
`define DLW_R_MAX         32'h3b9ac9ff

`define DLW_NSKIP         4
`define DLW_NALERT        8
`define DLW_ALERT_W       8

`endif

/* File: shared/dlw_pkg.sv */
// Types of the drive limit monitor
package dlw_pkg;
  typedef enum logic [2:0] {
    DLW_IDLE    = 3'b001,
    DLW_RAMP    = 3'b010,
    DLW_STEADY  = 3'b100
  } dlw_run_t;

  typedef enum logic [2:0] {
    DLW_A_ILOW  = 3'h0,
    DLW_A_IHIGH = 3'h1,
    DLW_A_FLOW  = 3'h2,
    DLW_A_FHIGH = 3'h3,
    DLW_A_RLOW  = 3'h4,
    DLW_A_RHIGH = 3'h5,
    DLW_A_PVLOW = 3'h6,
    DLW_A_PVHI  = 3'h7
  } dlw_alert_t;
endpackage : dlw_pkg

/* File: core/dlw_monitor.sv */
// Drive limit warning monitor with resonance skip bands and an APB register file
`include "dlw_consts.svh"

module dlw_monitor
  import dlw_pkg::*;
#(
  parameter logic [15:0] MAX_DRIVE_CURRENT = `DLW_I_MAX_DEF
) (
  // APB slave
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  // Drive measurements and run state, same clock
  input  wire  logic [15:0] motor_current,
  input  wire  logic [15:0] freq_demand,
  input  wire  logic [15:0] freq_actual,
  input  wire  logic [31:0] result_reference,
  input  wire  logic [31:0] process_value,
  input  wire  logic        run_cmd,
  input  wire  logic        remote_ref_sel,
  // Display, signal outputs, relays
  output logic       [15:0] freq_out,
  output logic              undercurrent_alert,
  output logic              overcurrent_alert,
  output logic              underspeed_alert,
  output logic              overspeed_alert,
  output logic              reference_under_alert,
  output logic              reference_over_alert,
  output logic              process_value_under_alert,
  output logic              process_value_over_alert,
  output logic              noload_trip,
  output logic              signal_out_a,
  output logic              signal_out_b,
  output logic              relay_out
);

  // Configuration registers
  logic [`DLW_CTRL_W-1:0] ctrl_r;
  logic [15:0]            skip_bw_r;
  logic [15:0]            skip_center_r [`DLW_NSKIP];
  logic [15:0]            cur_low_r;
  logic [15:0]            cur_high_r;
  logic [15:0]            freq_low_r;
  logic [15:0]            freq_high_r;
  logic signed [31:0]     ref_low_r;
  logic signed [31:0]     ref_high_r;
  logic signed [31:0]     process_value_floor_limit_r;
  logic signed [31:0]     process_value_ceiling_limit_r;
  logic [31:0]            route_r;
  logic [`DLW_NALERT-1:0] alert_r;
  logic                   trip_r;
  logic [15:0]            freq_out_r;
  logic [15:0]            freq_out_nxt;
  logic [2:0]             out_r;
  logic [31:0]            prdata_r;
  dlw_run_t               run_r;
  dlw_run_t               run_nxt;

  // Bus decode
  wire        acc      = psel & penable;
  wire        wr       = acc & pwrite;
  wire [15:0] wr16     = pwdata[15:0];
  wire        range_hi = ctrl_r[`DLW_CTRL_RANGE];
  wire [15:0] f_top    = range_hi ? `DLW_F_1000 : `DLW_F_120;
  wire        hit_ctrl = paddr == `DLW_OFF_CTRL;
  wire        hit_bw   = paddr == `DLW_OFF_BW;
  wire        hit_ilo  = paddr == `DLW_OFF_ILOW;
  wire        hit_ihi  = paddr == `DLW_OFF_IHIGH;
  wire        hit_flo  = paddr == `DLW_OFF_FLOW;
  wire        hit_fhi  = paddr == `DLW_OFF_FHIGH;
  wire        hit_rlo  = paddr == `DLW_OFF_RLOW;
  wire        hit_rhi  = paddr == `DLW_OFF_RHIGH;
  wire        hit_plo  = paddr == `DLW_OFF_PVLOW;
  wire        hit_phi  = paddr == `DLW_OFF_PVHIGH;
  wire        hit_rt   = paddr == `DLW_OFF_ROUTE;
  wire        hit_st   = paddr == `DLW_OFF_STATUS;
  wire        hit_fo   = paddr == `DLW_OFF_FREQ_OUT;
  wire [3:0]  hit_skip;
  wire        any_skip = |hit_skip;
  wire        mapped   = hit_ctrl | hit_bw | hit_ilo | hit_ihi | hit_flo | hit_fhi | hit_rlo
                       | hit_rhi | hit_plo | hit_phi | hit_rt | hit_st | hit_fo | any_skip;

  // Written limits are clamped against their partners so low never exceeds high
  wire [15:0] bw_clamp   = (wr16 > `DLW_BW_MAX) ? `DLW_BW_MAX : wr16;
  wire [15:0] skip_clamp = (wr16 > f_top) ? f_top : wr16;
  wire [15:0] ilo_clamp  = (wr16 > cur_high_r) ? cur_high_r : wr16;
  wire [15:0] ihi_lim    = (wr16 > MAX_DRIVE_CURRENT) ? MAX_DRIVE_CURRENT : wr16;
  wire [15:0] ihi_clamp  = (ihi_lim < cur_low_r) ? cur_low_r : ihi_lim;
  wire [15:0] flo_clamp  = (wr16 > freq_high_r) ? freq_high_r : wr16;
  wire [15:0] fhi_lim    = (wr16 > f_top) ? f_top : wr16;
  wire [15:0] fhi_clamp  = (fhi_lim < freq_low_r) ? freq_low_r : fhi_lim;
  wire signed [31:0] wsd = signed'(pwdata);
  wire signed [31:0] rlo_clamp = (wsd > ref_high_r) ? ref_high_r :
                                 (wsd < signed'(`DLW_R_MIN)) ? signed'(`DLW_R_MIN) : wsd;
  wire signed [31:0] rhi_clamp = (wsd < ref_low_r) ? ref_low_r :
                                 (wsd > signed'(`DLW_R_MAX)) ? signed'(`DLW_R_MAX) : wsd;
  wire signed [31:0] plo_clamp = (wsd > process_value_ceiling_limit_r) ?
                                 process_value_ceiling_limit_r :
                                 (wsd < signed'(`DLW_R_MIN)) ? signed'(`DLW_R_MIN) : wsd;
  wire signed [31:0] phi_clamp = (wsd < process_value_floor_limit_r) ?
                                 process_value_floor_limit_r :
                                 (wsd > signed'(`DLW_R_MAX)) ? signed'(`DLW_R_MAX) : wsd;

  // Skip bands: half width either side of each centre
  wire [15:0] half_bw = {1'b0, skip_bw_r[15:1]};
  wire [3:0]  in_band;
  wire [3:0]  above_mid;
  wire [15:0] band_lo [`DLW_NSKIP];
  wire [15:0] band_hi [`DLW_NSKIP];

  genvar g;
  generate
    for (g = 0; g < `DLW_NSKIP; g++) begin : g_skip
      wire [16:0] lo_w = {1'b0, skip_center_r[g]} - {1'b0, half_bw};
      wire [16:0] hi_w = {1'b0, skip_center_r[g]} + {1'b0, half_bw};
      assign hit_skip[g]  = paddr == (`DLW_OFF_SKIP0 + 12'(g) * `DLW_SKIP_STRIDE);
      assign band_lo[g]   = lo_w[16] ? `DLW_F_ZERO : lo_w[15:0];
      assign band_hi[g]   = hi_w[16] ? 16'hffff : hi_w[15:0];
      // A zero width disables the band
      assign in_band[g]   = (skip_bw_r != `DLW_F_ZERO) && (freq_demand > band_lo[g])
                          && (freq_demand < band_hi[g]);
      assign above_mid[g] = freq_demand >= skip_center_r[g];
    end
  endgenerate

  // Demand inside a band snaps to the nearer edge; bands are applied in order so
  // overlapping bands may still leave a residue, software should keep them apart
  always_comb begin
    freq_out_nxt = freq_demand;
    for (int i = 0; i < `DLW_NSKIP; i++) begin
      if (in_band[i]) begin
        freq_out_nxt = above_mid[i] ? band_hi[i] : band_lo[i];
      end
    end
  end

  // Run state: alerts only in steady running at reference
  wire at_ref = freq_actual == freq_out_r;
  always_comb begin
    run_nxt = run_r;
    unique case (run_r)
      DLW_IDLE: begin
        if (run_cmd) begin
          run_nxt = DLW_RAMP;
        end
      end
      DLW_RAMP: begin
        if (!run_cmd && freq_actual == `DLW_F_ZERO) begin
          run_nxt = DLW_IDLE;
        end else if (run_cmd && at_ref) begin
          run_nxt = DLW_STEADY;
        end
      end
      DLW_STEADY: begin
        if (!run_cmd || !at_ref) begin
          run_nxt = DLW_RAMP;
        end
      end
    endcase
  end

  wire steady = run_r == DLW_STEADY;
  wire ref_on = steady & remote_ref_sel;
  // Reference limits use the same scaled number in Hz or process units
  wire signed [31:0] ref_s = signed'(result_reference);
  wire signed [31:0] pv_s  = signed'(process_value);
  wire [`DLW_NALERT-1:0] alert_nxt;
  assign alert_nxt[DLW_A_ILOW]  = steady && motor_current < cur_low_r;
  assign alert_nxt[DLW_A_IHIGH] = steady && motor_current > cur_high_r;
  assign alert_nxt[DLW_A_FLOW]  = steady && freq_actual < freq_low_r;
  assign alert_nxt[DLW_A_FHIGH] = steady && freq_actual > freq_high_r;
  assign alert_nxt[DLW_A_RLOW]  = ref_on && ref_s < ref_low_r;
  assign alert_nxt[DLW_A_RHIGH] = ref_on && ref_s > ref_high_r;
  assign alert_nxt[DLW_A_PVLOW] = steady && pv_s < process_value_floor_limit_r;
  assign alert_nxt[DLW_A_PVHI]  = steady && pv_s > process_value_ceiling_limit_r;

  // Low-current event: warn code shows alert, trip code latches a trip
  wire noload_warn = ctrl_r[`DLW_CTRL_NOLOAD];
  wire [`DLW_NALERT-1:0] shown = alert_nxt & {{(`DLW_NALERT-1){1'b1}}, noload_warn};
  wire trip_set = alert_nxt[DLW_A_ILOW] & ~noload_warn;
  wire trip_clr = wr & hit_st & pwdata[`DLW_NALERT];
  wire [2:0] route_hit;
  assign route_hit[0] = |(alert_nxt & route_r[7:0]);
  assign route_hit[1] = |(alert_nxt & route_r[15:8]);
  assign route_hit[2] = |(alert_nxt & route_r[23:16]);

  // Read mux
  wire [31:0] skip_rd = hit_skip[0] ? {16'h0000, skip_center_r[0]} :
                        hit_skip[1] ? {16'h0000, skip_center_r[1]} :
                        hit_skip[2] ? {16'h0000, skip_center_r[2]} :
                                      {16'h0000, skip_center_r[3]};
  wire [31:0] rd_mux =
      hit_ctrl ? {29'h0, ctrl_r} :
      hit_bw   ? {16'h0000, skip_bw_r} :
      any_skip ? skip_rd :
      hit_ilo  ? {16'h0000, cur_low_r} :
      hit_ihi  ? {16'h0000, cur_high_r} :
      hit_flo  ? {16'h0000, freq_low_r} :
      hit_fhi  ? {16'h0000, freq_high_r} :
      hit_rlo  ? ref_low_r :
      hit_rhi  ? ref_high_r :
      hit_plo  ? process_value_floor_limit_r :
      hit_phi  ? process_value_ceiling_limit_r :
      hit_rt   ? route_r :
      hit_st   ? {20'h0, run_r, trip_r, alert_r} :
      hit_fo   ? {16'h0000, freq_out_r} : 32'h0000_0000;

  // Configuration writes; zero-wait APB, errors on unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r                        <= `DLW_CTRL_RST;
      skip_bw_r                     <= `DLW_F_ZERO;
      cur_low_r                     <= `DLW_I_ZERO;
      cur_high_r                    <= MAX_DRIVE_CURRENT;
      freq_low_r                    <= `DLW_F_ZERO;
      freq_high_r                   <= `DLW_F_120;
      ref_low_r                     <= signed'(`DLW_R_MIN);
      ref_high_r                    <= signed'(`DLW_R_MIN);
      process_value_floor_limit_r   <= signed'(`DLW_R_MIN);
      process_value_ceiling_limit_r <= signed'(`DLW_R_MAX);
      route_r                       <= 32'h0000_0000;
    end else if (wr) begin
      if (hit_ctrl) ctrl_r <= pwdata[`DLW_CTRL_W-1:0];
      if (hit_bw)   skip_bw_r <= bw_clamp;
      if (hit_ilo)  cur_low_r <= ilo_clamp;
      if (hit_ihi)  cur_high_r <= ihi_clamp;
      if (hit_flo)  freq_low_r <= flo_clamp;
      if (hit_fhi)  freq_high_r <= fhi_clamp;
      if (hit_rlo)  ref_low_r <= rlo_clamp;
      if (hit_rhi)  ref_high_r <= rhi_clamp;
      if (hit_plo)  process_value_floor_limit_r <= plo_clamp;
      if (hit_phi)  process_value_ceiling_limit_r <= phi_clamp;
      if (hit_rt)   route_r <= {8'h00, pwdata[23:0]};
    end
  end

  generate
    for (g = 0; g < `DLW_NSKIP; g++) begin : g_skip_reg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          skip_center_r[g] <= `DLW_F_120;
        end else if (wr && hit_skip[g]) begin
          skip_center_r[g] <= skip_clamp;
        end
      end
    end
  endgenerate

  // Live state; alerts are not sticky so they drop as soon as the cause goes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r      <= DLW_IDLE;
      alert_r    <= 8'h00;
      trip_r     <= 1'b0;
      freq_out_r <= `DLW_F_ZERO;
      out_r      <= 3'h0;
      prdata_r   <= 32'h0000_0000;
    end else begin
      run_r      <= run_nxt;
      alert_r    <= shown;
      trip_r     <= trip_set | (trip_r & ~trip_clr);
      freq_out_r <= freq_out_nxt;
      out_r      <= route_hit;
      prdata_r   <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_r;
    end
  end

  // Unmapped access answers with an error; ready is always high
  logic pslverr_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= psel & ~penable & ~mapped;
    end
  end

  assign prdata                    = prdata_r;
  assign pready                    = 1'b1;
  assign pslverr                   = pslverr_r;
  assign freq_out                  = freq_out_r;
  assign undercurrent_alert        = alert_r[DLW_A_ILOW];
  assign overcurrent_alert         = alert_r[DLW_A_IHIGH];
  assign underspeed_alert          = alert_r[DLW_A_FLOW];
  assign overspeed_alert           = alert_r[DLW_A_FHIGH];
  assign reference_under_alert     = alert_r[DLW_A_RLOW];
  assign reference_over_alert      = alert_r[DLW_A_RHIGH];
  assign process_value_under_alert = alert_r[DLW_A_PVLOW];
  assign process_value_over_alert  = alert_r[DLW_A_PVHI];
  assign noload_trip               = trip_r;
  assign signal_out_a              = out_r[0];
  assign signal_out_b              = out_r[1];
  assign relay_out                 = out_r[2];

endmodule // dlw_monitor

/* File: tb/dlw_monitor_props.sv */
// Port-level assertions for the drive limit monitor
`include "dlw_consts.svh"
module dlw_monitor_props (
  // APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  // Drive side
  input wire logic [15:0] freq_demand,
  input wire logic [15:0] freq_actual,
  input wire logic [15:0] freq_out,
  input wire logic        run_cmd,
  input wire logic        remote_ref_sel,
  // Alerts and outputs
  input wire logic        undercurrent_alert,
  input wire logic        overcurrent_alert,
  input wire logic        underspeed_alert,
  input wire logic        overspeed_alert,
  input wire logic        reference_under_alert,
  input wire logic        reference_over_alert,
  input wire logic        process_value_under_alert,
  input wire logic        process_value_over_alert,
  input wire logic        noload_trip,
  input wire logic        signal_out_a,
  input wire logic        relay_out
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic [7:0] al = {process_value_over_alert, process_value_under_alert,
                         reference_over_alert, reference_under_alert, overspeed_alert,
                         underspeed_alert, overcurrent_alert, undercurrent_alert};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_IDLE_QUIET: assert property (!run_cmd |-> ##2 al == 8'h00)
    else $error("alert while stopped");
  AST_STEADY_GATE: assert property (al != 8'h00 |->
    $past(run_cmd && freq_actual == freq_out, 2))
    else $error("alert before reference reached");
  AST_REMOTE_ONLY: assert property (
    (reference_under_alert || reference_over_alert) |-> $past(remote_ref_sel))
    else $error("reference alert without remote source");
  AST_SKIP_BOUND: assert property ($past(presetn) |->
    ((freq_out >= $past(freq_demand)) ? freq_out - $past(freq_demand) :
    $past(freq_demand) - freq_out) <= 16'h01f4)
    else $error("skip shift wider than half band");
  AST_ERR_ACCESS: assert property (pslverr |-> psel && penable)
    else $error("error response outside access");
  AST_TRIP_HOLD: assert property ($past(noload_trip && !(psel && penable && pwrite &&
    paddr == `DLW_OFF_STATUS && pwdata[8])) |-> noload_trip)
    else $error("trip dropped without clear");
  AST_ROUTE_CAUSE: assert property ((signal_out_a || relay_out) |->
    al != 8'h00 || noload_trip)
    else $error("routed output without alert");
  AST_CURR_EXCL: assert property (!(undercurrent_alert && overcurrent_alert))
    else $error("low and high current together");
  AST_FREQ_EXCL: assert property (!(underspeed_alert && overspeed_alert))
    else $error("low and high frequency together");
endmodule // dlw_monitor_props

bind dlw_monitor dlw_monitor_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .freq_demand(freq_demand), .freq_actual(freq_actual), .freq_out(freq_out),
  .run_cmd(run_cmd), .remote_ref_sel(remote_ref_sel),
  .undercurrent_alert(undercurrent_alert), .overcurrent_alert(overcurrent_alert),
  .underspeed_alert(underspeed_alert), .overspeed_alert(overspeed_alert),
  .reference_under_alert(reference_under_alert), .reference_over_alert(reference_over_alert),
  .process_value_under_alert(process_value_under_alert),
  .process_value_over_alert(process_value_over_alert), .noload_trip(noload_trip),
  .signal_out_a(signal_out_a), .relay_out(relay_out));

/* File: tb/dlw_drive_model.sv */
// Behavioural drive core: ramps the actual frequency toward the commanded one
module dlw_drive_model #(
  parameter logic [15:0] STEP = 16'h0032
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Commands
  input  wire logic        run_cmd,
  input  wire logic        slow,
  input  wire logic [15:0] freq_out,
  // Measured speed
  output logic      [15:0] freq_actual
);
  timeunit 1ns;
  timeprecision 100ps;
  logic             tgl_r;
  wire  logic [15:0] target = run_cmd ? freq_out : 16'h0000;
  wire  logic        up     = target > freq_actual;
  wire  logic [15:0] gap    = up ? target - freq_actual : freq_actual - target;
  wire  logic [15:0] stp    = (gap < STEP) ? gap : STEP;
  // A slow drive moves every other cycle only, stretching the ramp phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_actual <= 16'h0000;
      tgl_r       <= 1'b0;
    end else begin
      tgl_r <= ~tgl_r;
      if (!slow || tgl_r) begin
        freq_actual <= up ? freq_actual + stp : freq_actual - stp;
      end
    end
  end
endmodule // dlw_drive_model

/* File: tb/dlw_monitor_test.sv */
// Self-checking bench for the drive limit monitor
`include "dlw_consts.svh"
module dlw_monitor_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [15:0] f, i; logic [31:0] rf, pv; logic rem; logic [7:0] e;} dlw_row_t;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        run_cmd = 1'b0, remote_ref_sel = 1'b0, slow = 1'b0;
  logic        pready, pslverr, noload_trip, signal_out_a, signal_out_b, relay_out;
  logic        mon_err;
  logic [11:0] paddr = 12'h000;
  logic [15:0] motor_current = 16'h012c, freq_demand = 16'h0000, freq_actual, freq_out;
  logic [31:0] pwdata = 32'h0, result_reference = 32'h0, process_value = 32'h0, prdata, mon_rd;
  wire  [7:0]  al;
  int          errors = 0, samples_checked = 0, cycles = 0;
  logic [11:0] ra[12] = '{12'h000, 12'h004, 12'h008, 12'h014, 12'h018, 12'h01c, 12'h020,
                          12'h024, 12'h028, 12'h02c, 12'h034, 12'h038};
  logic [31:0] rv[12] = '{32'h1, 32'h0, 32'h4b0, 32'h4b0, 32'h0, 32'hffff, 32'h0, 32'h4b0,
                          32'hc4653601, 32'hc4653601, 32'h3b9ac9ff, 32'h0};
  logic [11:0] ca[10] = '{12'h000, 12'h01c, 12'h018, 12'h024, 12'h020, 12'h02c, 12'h028,
                          12'h030, 12'h034, 12'h038};
  logic [31:0] cv[10] = '{32'h5, 32'h1f4, 32'h64, 32'h3e8, 32'h64, 32'h1388, 32'hfffffc18,
                          32'h0, 32'h7d0, 32'h00800802};
  logic [15:0] si[6] = '{16'h028a, 16'h0226, 16'h0258, 16'h02bc, 16'h01f5, 16'h047e};
  logic [15:0] so[6] = '{16'h02bc, 16'h01f4, 16'h02bc, 16'h02bc, 16'h01f4, 16'h044c};
  dlw_row_t rows[10] = '{
    '{16'h01f4, 16'h012c, 32'h7d0, 32'h3e8, 1'b1, 8'h00},
    '{16'h01f4, 16'h0032, 32'h7d0, 32'h3e8, 1'b1, 8'h01},
    '{16'h01f4, 16'h0258, 32'h7d0, 32'h3e8, 1'b1, 8'h02},
    '{16'h0032, 16'h012c, 32'h7d0, 32'h3e8, 1'b1, 8'h04},
    '{16'h044c, 16'h012c, 32'h7d0, 32'h3e8, 1'b1, 8'h08},
    '{16'h01f4, 16'h012c, 32'hfffff830, 32'h3e8, 1'b1, 8'h10},
    '{16'h01f4, 16'h012c, 32'hfffff830, 32'h3e8, 1'b0, 8'h00},
    '{16'h01f4, 16'h012c, 32'h1770, 32'h3e8, 1'b1, 8'h20},
    '{16'h01f4, 16'h012c, 32'h7d0, 32'hfffffffb, 1'b1, 8'h40},
    '{16'h01f4, 16'h012c, 32'h7d0, 32'hbb8, 1'b1, 8'h80}};

  dlw_monitor DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .motor_current(motor_current), .freq_demand(freq_demand),
    .freq_actual(freq_actual), .result_reference(result_reference),
    .process_value(process_value), .run_cmd(run_cmd), .remote_ref_sel(remote_ref_sel),
    .freq_out(freq_out), .undercurrent_alert(al[0]), .overcurrent_alert(al[1]),
    .underspeed_alert(al[2]), .overspeed_alert(al[3]), .reference_under_alert(al[4]),
    .reference_over_alert(al[5]), .process_value_under_alert(al[6]),
    .process_value_over_alert(al[7]), .noload_trip(noload_trip), .signal_out_a(signal_out_a),
    .signal_out_b(signal_out_b), .relay_out(relay_out));
  dlw_drive_model MDL (.pclk(pclk), .presetn(presetn), .run_cmd(run_cmd), .slow(slow),
    .freq_out(freq_out), .freq_actual(freq_actual));

  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request stands until pready is seen high at a rising edge; the answer is taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    mon_rd  = prdata;
    mon_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, mon_rd);
  endtask
  task automatic settle;
    int n = 0;
    repeat (3) @(posedge pclk);
    while (freq_actual !== freq_out && n < 500) begin
      @(posedge pclk);
      n++;
    end
    repeat (4) @(posedge pclk);
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ra[k]) rd(ra[k], rv[k], "reset value");
    rd(12'h044, 32'h0, "unmapped data");
    chk("unmapped err", 32'h1, {31'h0, mon_err});
    foreach (ca[k]) apb(1'b1, ca[k], cv[k]);
    apb(1'b1, `DLW_OFF_ILOW, 32'h1000);
    rd(`DLW_OFF_ILOW, 32'h1f4, "low current clamp");
    apb(1'b1, `DLW_OFF_ILOW, 32'h64);
    foreach (rows[k]) begin
      @(posedge pclk);
      freq_demand      <= rows[k].f;
      motor_current    <= rows[k].i;
      result_reference <= rows[k].rf;
      process_value    <= rows[k].pv;
      remote_ref_sel   <= rows[k].rem;
      slow             <= k[0];
      run_cmd          <= 1'b1;
      settle();
      chk("al", 32'(rows[k].e), 32'(al));
      chk("routes", 32'({rows[k].e[7], rows[k].e[3], rows[k].e[1]}),
          32'({relay_out, signal_out_b, signal_out_a}));
    end
    @(posedge pclk);
    run_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("alerts stopped", 32'h0, {24'h0, al});
    run_cmd <= 1'b1;
    settle();
    chk("alerts resumed", 32'h80, {24'h0, al});
    process_value <= 32'h3e8;
    apb(1'b1, `DLW_OFF_CTRL, 32'h4);
    @(posedge pclk);
    motor_current <= 16'h0032;
    repeat (4) @(posedge pclk);
    chk("trip", 32'h2, {30'h0, noload_trip, al[0]});
    rd(`DLW_OFF_STATUS, 32'h900, "status");
    motor_current <= 16'h012c;
    apb(1'b1, `DLW_OFF_STATUS, 32'h100);
    repeat (2) @(posedge pclk);
    chk("trip cleared", 32'h0, {31'h0, noload_trip});
    apb(1'b1, `DLW_OFF_BW, 32'h500);
    rd(`DLW_OFF_BW, 32'h3e8, "width clamp");
    apb(1'b1, `DLW_OFF_SKIP0 + 12'h004, 32'h3000);
    rd(`DLW_OFF_SKIP0 + 12'h004, 32'h4b0, "skip clamp");
    apb(1'b1, `DLW_OFF_BW, 32'hc8);
    apb(1'b1, `DLW_OFF_SKIP0, 32'h258);
    foreach (si[k]) begin
      @(posedge pclk);
      freq_demand <= si[k];
      repeat (3) @(posedge pclk);
      chk("skip", {16'h0, so[k]}, {16'h0, freq_out});
    end
    // Wide output range lifts the skip ceiling
    apb(1'b1, `DLW_OFF_CTRL, 32'h3);
    apb(1'b1, `DLW_OFF_SKIP0 + 12'h004, 32'h3000);
    rd(`DLW_OFF_SKIP0 + 12'h004, 32'h2710, "wide skip clamp");
    // Reset in mid-run: outputs drop at once, settings return to defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("reset outputs", 32'h0, {7'h0, noload_trip, al, freq_out});
    presetn <= 1'b1;
    rd(`DLW_OFF_BW, 32'h0, "width after reset");
    rd(`DLW_OFF_SKIP0 + 12'h004, 32'h4b0, "skip after reset");
    stop_test();
  end
endmodule // dlw_monitor_test
